//--- tcr_timer_defines.svh
// Purpose: Offsets, field positions, reset values and timing figures of the timer control block
// Assumes: 10 MHz system clock; printed offsets are register indexes, byte address = 4 x index
// Notes:   Definitions only
`ifndef TCR_TIMER_DEFINES_SVH
`define TCR_TIMER_DEFINES_SVH

// Register indexes
`define TCR_IDX_CARRY   6'h17
`define TCR_IDX_RATE    6'h18
`define TCR_IDX_T3CTL   6'h28
`define TCR_IDX_T2CTL   6'h29
`define TCR_IDX_T1CTL   6'h2A
`define TCR_IDX_T0CTL   6'h2B
`define TCR_IDX_T0MODE  6'h2C
`define TCR_IDX_ISTAT   6'h30
`define TCR_IDX_IMASK   6'h31

// Field positions
`define TCR_CY_BIT      0
`define TCR_CTL_RUN     3
`define TCR_CTL_CLR     2
`define TCR_CTL_CK      0
`define TCR_T3_SEL      3
`define TCR_T3_RUN      1
`define TCR_T3_CLR      0
`define TCR_MD_OVF      3
`define TCR_MD_GCE      2
`define TCR_MD_GOE      1
`define TCR_MD_MODE     0
`define TCR_IRQ_CARRY   0
`define TCR_IRQ_OVF     1

// Reset values
`define TCR_RST_NIB     4'h0
`define TCR_RST_BIT     1'b0
`define TCR_CE_CARRY    1'b1

// AXI responses
`define TCR_RESP_OKAY   2'h0
`define TCR_RESP_SLVERR 2'h2

// Timing: clock and tick rates in Hz, periods in cycles derived from them
`define TCR_CLK_HZ      10000000
`define TCR_BT_HZ0      10
`define TCR_BT_HZ1      20
`define TCR_BT_HZ2      50
`define TCR_BT_HZ3      100
`define TCR_CT_HZ0      100000
`define TCR_CT_HZ1      10000
`define TCR_CT_HZ2      2000
`define TCR_CT_HZ3      1000
`define TCR_CYC(hz)     (`TCR_CLK_HZ / (hz))

`endif

//--- tcr_pkg.sv
// Purpose: Types of the timer control block
// Assumes: Constants live in tcr_timer_defines.svh
// Notes:   One packed state struct for the top module
package tcr_pkg;

   typedef logic [3:0] tcr_nib_t;

   typedef struct packed {
      // Register contents
      logic          carry;
      logic [1:0]    rate;
      tcr_nib_t [3:0] tmCtl;
      logic [2:0]    mode;
      logic          ovf;
      logic [3:0]    clrPulse;
      logic [1:0]    intStat;
      logic [1:0]    intMask;
      logic          irq;
      // AXI4-Lite slave
      logic          awReady;
      logic          awTaken;
      logic [5:0]    awIdx;
      logic          awBad;
      logic          wReady;
      logic          wTaken;
      tcr_nib_t      wData;
      logic          wLane;
      logic          bValid;
      logic [1:0]    bResp;
      logic          arReady;
      logic          rValid;
      tcr_nib_t      rData;
      logic [1:0]    rResp;
   } tcr_state_s;

endpackage

//--- tcr_rate_divider.sv
// Purpose: Prescaler giving a one-cycle tick at one of four selectable periods
// Assumes: Periods are at least two cycles
// Notes:   Restart holds the count at zero
`timescale 1ns/10ps
`default_nettype none
module tcr_rate_divider #(
   parameter int W  = 20,
   parameter int P0 = 100,
   parameter int P1 = 1000,
   parameter int P2 = 5000,
   parameter int P3 = 10000
) (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       resetn,
   // Control
   input  wire logic [1:0] rateSel,
   input  wire logic       enable,
   input  wire logic       restart,
   // Tick
   output var  logic       tick
);

   typedef struct packed {
      logic [W-1:0] cnt;
      logic         tick;
   } tcr_div_s;

   tcr_div_s     div_reg;
   tcr_div_s     div_next;
   logic [W-1:0] lastCnt;

   always_comb begin
      unique case (rateSel)
         2'h0: lastCnt = W'(P0 - 1);
         2'h1: lastCnt = W'(P1 - 1);
         2'h2: lastCnt = W'(P2 - 1);
         2'h3: lastCnt = W'(P3 - 1);
      endcase
   end

   always_comb begin
      div_next      = div_reg;
      div_next.tick = 1'b0;
      if (restart) begin
         div_next.cnt = '0;
      end else if (enable) begin
         // Compare with >= so a shorter period chosen mid-count still wraps
         if (div_reg.cnt >= lastCnt) begin
            div_next.cnt  = '0;
            div_next.tick = 1'b1;
         end else begin
            div_next.cnt = div_reg.cnt + W'(1);
         end
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         div_reg <= '0;
      end else begin
         div_reg <= div_next;
      end
   end

   assign tick = div_reg.tick;

endmodule
`default_nettype wire

//--- tcr_timer_control.sv
// Purpose: Control and status registers of the basic timer and timers 0 to 3, on AXI4-Lite
// Assumes: Reset-class inputs are synchronous levels; overflow event is a one-cycle pulse
// Notes:   4-bit registers sit in the low bits of aligned words; upper bits read as zero
//
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "tcr_timer_defines.svh"

// Overview of operation
// - Carry reads bit0, read clears, reset-class values
// - Two-bit field picks 10/20/50/100 Hz tick
// - Select bit: 0 gives DAC, 1 timer three
// - Timer three run gates; clear one resets
// - Timer two run gates; clear one resets
// - Timer one run gates; clear one resets
// - Timer zero run gates; clear one resets
// - Clock field picks 100k/10k/2k/1k Hz count
// - Overflow bit reads one after counter overflow
// - Mode bit modulo/gate; close edge rise/fall
// - Gate open edge bit selects rise/fall
// - Timer control and mode registers follow watchdog and clock stop resets, tick rate only watchdog; CE reset leaves them unchanged
module tcr_timer_control
   import tcr_pkg::*;
#(
   // Periods in clock cycles; each must be at least two for one-cycle ticks
   parameter int BT_P0 = `TCR_CYC(`TCR_BT_HZ0),
   parameter int BT_P1 = `TCR_CYC(`TCR_BT_HZ1),
   parameter int BT_P2 = `TCR_CYC(`TCR_BT_HZ2),
   parameter int BT_P3 = `TCR_CYC(`TCR_BT_HZ3),
   parameter int CT_P0 = `TCR_CYC(`TCR_CT_HZ0),
   parameter int CT_P1 = `TCR_CYC(`TCR_CT_HZ1),
   parameter int CT_P2 = `TCR_CYC(`TCR_CT_HZ2),
   parameter int CT_P3 = `TCR_CYC(`TCR_CT_HZ3)
) (
   // Clock and power-on reset
   input  wire logic       clk,
   input  wire logic       resetn,
   // Other reset classes
   input  wire logic       watchdogStackReset,
   input  wire logic       ceReset,
   input  wire logic       clockStop,
   // Events from the counter datapath
   input  wire logic       zerothTimerOverflowEvent,
   // AXI4-Lite write address
   input  wire logic       s_axi_awvalid,
   output var  logic       s_axi_awready,
   input  wire logic [7:0] s_axi_awaddr,
   input  wire logic [2:0] s_axi_awprot,
   // AXI4-Lite write data
   input  wire logic       s_axi_wvalid,
   output var  logic       s_axi_wready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0] s_axi_wstrb,
   // AXI4-Lite write response
   output var  logic       s_axi_bvalid,
   input  wire logic       s_axi_bready,
   output var  logic [1:0] s_axi_bresp,
   // AXI4-Lite read address
   input  wire logic       s_axi_arvalid,
   output var  logic       s_axi_arready,
   input  wire logic [7:0] s_axi_araddr,
   input  wire logic [2:0] s_axi_arprot,
   // AXI4-Lite read data
   output var  logic       s_axi_rvalid,
   input  wire logic       s_axi_rready,
   output var  logic [31:0] s_axi_rdata,
   output var  logic [1:0] s_axi_rresp,
   // Basic timer
   output var  logic       basicTick,
   output var  logic [1:0] tickRateSel,
   // Timer zero to two controls, index is the timer number
   output var  logic [2:0] timerRun,
   output var  logic [2:0] timerClear,
   output var  logic [5:0] timerClkSel,
   output var  logic [2:0] countTick,
   // Timer three
   output var  logic       thirdTimerVsDacSel,
   output var  logic       thirdTimerRun,
   output var  logic       thirdTimerClear,
   // Timer zero mode
   output var  logic       zerothTimerCountMode,
   output var  logic       gateCloseEdgeSel,
   output var  logic       gateOpenEdgeSel,
   // Interrupt
   output var  logic       irq
);

   tcr_state_s st_reg;
   tcr_state_s st_next;
   logic       basicTickW;
   logic [2:0] countTickW;
   logic       rdTake;
   logic [5:0] rdIdx;
   logic       rdBad;
   logic       rdHit;
   tcr_nib_t   rdVal;

   // Basic timer tick source; its tick sets the carry flag
   // The basic tick never stops, so the carry flag keeps marking time
   tcr_rate_divider #(
      .W (20),
      .P0(BT_P0),
      .P1(BT_P1),
      .P2(BT_P2),
      .P3(BT_P3)
   ) u_basic_div (
      .clk    (clk),
      .resetn (resetn),
      .rateSel(st_reg.rate),
      .enable (1'b1),
      .restart(1'b0),
      .tick   (basicTickW)
   );

   // Count clocks of timers zero to two
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_count_div
         tcr_rate_divider #(
            .W (20),
            .P0(CT_P0),
            .P1(CT_P1),
            .P2(CT_P2),
            .P3(CT_P3)
         ) u_count_div (
            .clk    (clk),
            .resetn (resetn),
            .rateSel(st_reg.tmCtl[gi][`TCR_CTL_CK +: 2]),
            .enable (st_reg.tmCtl[gi][`TCR_CTL_RUN]),
            // A clear restarts the prescaler so the next count period is full
            .restart(st_reg.clrPulse[gi]),
            .tick   (countTickW[gi])
         );
      end
   endgenerate

   // Read data are captured at the address handshake, so software sees
   // the flag value from before any read-clear in that same cycle
   // Read decode
   assign rdTake = s_axi_arvalid && st_reg.arReady;
   assign rdIdx  = s_axi_araddr[7:2];
   assign rdBad  = (s_axi_araddr[1:0] != 2'h0);

   always_comb begin
      rdHit = 1'b1;
      rdVal = `TCR_RST_NIB;
      unique case (rdIdx)
         `TCR_IDX_CARRY:  rdVal[`TCR_CY_BIT] = st_reg.carry;
         `TCR_IDX_RATE:   rdVal[1:0] = st_reg.rate;
         `TCR_IDX_T3CTL:  rdVal = st_reg.tmCtl[3];
         `TCR_IDX_T2CTL:  rdVal = st_reg.tmCtl[2];
         `TCR_IDX_T1CTL:  rdVal = st_reg.tmCtl[1];
         `TCR_IDX_T0CTL:  rdVal = st_reg.tmCtl[0];
         `TCR_IDX_T0MODE: rdVal = {st_reg.ovf, st_reg.mode};
         `TCR_IDX_ISTAT:  rdVal[1:0] = st_reg.intStat;
         `TCR_IDX_IMASK:  rdVal[1:0] = st_reg.intMask;
         default:         rdHit = 1'b0;
      endcase
      // Misaligned addresses override any hit
      if (rdBad) begin
         rdHit = 1'b0;
         rdVal = `TCR_RST_NIB;
      end
   end

   always_comb begin
      st_next          = st_reg;
      st_next.clrPulse = 4'h0;

      // Write address and data are taken independently
      if (s_axi_awvalid && st_reg.awReady) begin
         st_next.awTaken = 1'b1;
         st_next.awIdx   = s_axi_awaddr[7:2];
         st_next.awBad   = (s_axi_awaddr[1:0] != 2'h0);
      end
      if (s_axi_wvalid && st_reg.wReady) begin
         st_next.wTaken = 1'b1;
         st_next.wData  = s_axi_wdata[3:0];
         st_next.wLane  = s_axi_wstrb[0];
      end

      // Perform the write once both halves are held
      // A cleared strobe lane still completes with an okay response
      if (st_reg.awTaken && st_reg.wTaken && !st_reg.bValid) begin
         st_next.awTaken = 1'b0;
         st_next.wTaken  = 1'b0;
         st_next.bValid  = 1'b1;
         st_next.bResp   = `TCR_RESP_OKAY;
         if (st_reg.awBad) begin
            st_next.bResp = `TCR_RESP_SLVERR;
         end else begin
            unique case (st_reg.awIdx)
               `TCR_IDX_CARRY: begin
               end
               `TCR_IDX_RATE: begin
                  if (st_reg.wLane) begin
                     st_next.rate = st_reg.wData[1:0];
                  end
               end
               `TCR_IDX_T3CTL: begin
                  if (st_reg.wLane) begin
                     // Bit two stays zero; the clear bit never stores
                     st_next.tmCtl[3] = 4'h0;
                     st_next.tmCtl[3][`TCR_T3_SEL] = st_reg.wData[`TCR_T3_SEL];
                     st_next.tmCtl[3][`TCR_T3_RUN] = st_reg.wData[`TCR_T3_RUN];
                     st_next.clrPulse[3] = st_reg.wData[`TCR_T3_CLR];
                  end
               end
               `TCR_IDX_T2CTL, `TCR_IDX_T1CTL, `TCR_IDX_T0CTL: begin
                  if (st_reg.wLane) begin
                     for (int i = 0; i < 3; i++) begin
                        if (st_reg.awIdx == (`TCR_IDX_T0CTL - 6'(i))) begin
                           st_next.tmCtl[i] = st_reg.wData;
                           st_next.tmCtl[i][`TCR_CTL_CLR] = 1'b0;
                           st_next.clrPulse[i] = st_reg.wData[`TCR_CTL_CLR];
                        end
                     end
                  end
               end
               `TCR_IDX_T0MODE: begin
                  if (st_reg.wLane) begin
                     st_next.mode = st_reg.wData[2:0];
                     // Writing zero to the overflow bit acknowledges it
                     if (!st_reg.wData[`TCR_MD_OVF]) begin
                        st_next.ovf = 1'b0;
                     end
                  end
               end
               `TCR_IDX_ISTAT: begin
               end
               `TCR_IDX_IMASK: begin
                  if (st_reg.wLane) begin
                     st_next.intMask = st_reg.wData[1:0];
                  end
               end
               // Unmapped words answer with an error and change nothing
               default: st_next.bResp = `TCR_RESP_SLVERR;
            endcase
         end
      end
      if (st_reg.bValid && s_axi_bready) begin
         st_next.bValid = 1'b0;
      end
      // Ready stays low while a response waits, so one write is open at most
      st_next.awReady = !st_next.awTaken && !st_next.bValid;
      st_next.wReady  = !st_next.wTaken && !st_next.bValid;

      // Read channel, with read side effects
      if (rdTake) begin
         st_next.arReady = 1'b0;
         st_next.rValid  = 1'b1;
         st_next.rData   = rdVal;
         st_next.rResp   = rdHit ? `TCR_RESP_OKAY : `TCR_RESP_SLVERR;
         if (rdHit && rdIdx == `TCR_IDX_CARRY) begin
            st_next.carry = 1'b0;
         end
         if (rdHit && rdIdx == `TCR_IDX_ISTAT) begin
            st_next.intStat = 2'h0;
         end
      end
      if (st_reg.rValid && s_axi_rready) begin
         st_next.rValid  = 1'b0;
         st_next.arReady = 1'b1;
      end

      // Clearing timer zero also drops its overflow status
      if (st_next.clrPulse[0]) begin
         st_next.ovf = 1'b0;
      end

      // Hardware sets win over software clears
      // so an event in the cycle of a read is never lost
      if (basicTickW) begin
         st_next.carry = 1'b1;
         st_next.intStat[`TCR_IRQ_CARRY] = 1'b1;
      end
      if (zerothTimerOverflowEvent) begin
         st_next.ovf = 1'b1;
         st_next.intStat[`TCR_IRQ_OVF] = 1'b1;
      end

      // Reset classes other than power-on
      // Watchdog keeps carry and the interrupt registers; CE only sets carry;
      // clock stop keeps the tick rate and carry
      if (watchdogStackReset) begin
         st_next.rate     = 2'h0;
         st_next.tmCtl    = '0;
         st_next.mode     = 3'h0;
         st_next.ovf      = `TCR_RST_BIT;
         st_next.clrPulse = 4'h0;
      end
      if (ceReset) begin
         st_next.carry = `TCR_CE_CARRY;
      end
      if (clockStop) begin
         st_next.tmCtl    = '0;
         st_next.mode     = 3'h0;
         st_next.ovf      = `TCR_RST_BIT;
         st_next.clrPulse = 4'h0;
      end

      // Taken from the next state so irq moves with the status bits
      st_next.irq = |(st_next.intStat & st_next.intMask);
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st_reg         <= '0;
         // Ready outputs come up high so a request may be taken at once
         st_reg.awReady <= 1'b1;
         st_reg.wReady  <= 1'b1;
         st_reg.arReady <= 1'b1;
      end else begin
         st_reg <= st_next;
      end
   end

   // Outputs straight from state
   assign s_axi_awready = st_reg.awReady;
   assign s_axi_wready  = st_reg.wReady;
   assign s_axi_bvalid  = st_reg.bValid;
   assign s_axi_bresp   = st_reg.bResp;
   assign s_axi_arready = st_reg.arReady;
   assign s_axi_rvalid  = st_reg.rValid;
   assign s_axi_rdata   = {28'h0000000, st_reg.rData};
   assign s_axi_rresp   = st_reg.rResp;

   assign basicTick   = basicTickW;
   assign tickRateSel = st_reg.rate;
   assign countTick   = countTickW;
   // Clear pulses come from the state register and last exactly one cycle
   generate
      for (gi = 0; gi < 3; gi++) begin : g_timer_out
         assign timerRun[gi]            = st_reg.tmCtl[gi][`TCR_CTL_RUN];
         assign timerClear[gi]          = st_reg.clrPulse[gi];
         assign timerClkSel[2*gi +: 2]  = st_reg.tmCtl[gi][`TCR_CTL_CK +: 2];
      end
   endgenerate
   assign thirdTimerVsDacSel   = st_reg.tmCtl[3][`TCR_T3_SEL];
   assign thirdTimerRun        = st_reg.tmCtl[3][`TCR_T3_RUN];
   assign thirdTimerClear      = st_reg.clrPulse[3];
   assign zerothTimerCountMode = st_reg.mode[`TCR_MD_MODE];
   assign gateCloseEdgeSel     = st_reg.mode[`TCR_MD_GCE];
   assign gateOpenEdgeSel      = st_reg.mode[`TCR_MD_GOE];
   assign irq                  = st_reg.irq;

endmodule
`default_nettype wire

//--- tcr_timer_control_props.sv
// Purpose: Concurrent checks on the ports of the timer control block
// Assumes: Clear and tick pulses last one cycle; reset classes are sync levels
// Notes:   Bound to every instance of the block
`timescale 1ns/10ps
`default_nettype none
`include "tcr_timer_defines.svh"
module tcr_timer_control_props (
   // Clock and resets
   input wire logic        clk,
   input wire logic        resetn,
   input wire logic        watchdogStackReset,
   input wire logic        clockStop,
   // Bus
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [7:0]  s_axi_araddr,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_rvalid,
   input wire logic [31:0] s_axi_rdata,
   // Timer controls
   input wire logic        basicTick,
   input wire logic [1:0]  tickRateSel,
   input wire logic [2:0]  timerRun,
   input wire logic [2:0]  timerClear,
   input wire logic [5:0]  timerClkSel,
   input wire logic [2:0]  countTick,
   input wire logic        thirdTimerVsDacSel,
   input wire logic        thirdTimerRun,
   input wire logic        thirdTimerClear,
   input wire logic        zerothTimerCountMode
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);

   sequence arTaken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   sequence wrDone;
      $rose(s_axi_bvalid);
   endsequence

   AST_CLR_ONESHOT: assert property (|timerClear |-> wrDone ##1 timerClear == 3'h0)
      else $error("timer clear pulse not tied to one write");
   AST_T3_CLR: assert property (thirdTimerClear |-> wrDone ##1 !thirdTimerClear)
      else $error("third timer clear pulse not tied to one write");
   AST_RUN_GATES: assert property (
      (countTick & ~(timerRun | $past(timerRun) | $past(timerRun, 2))) == 3'h0)
      else $error("count tick while timer stopped");
   AST_RDATA_UPPER: assert property (s_axi_rvalid |-> s_axi_rdata[31:4] == 28'h0)
      else $error("upper read bits not zero");
   AST_CARRY_READ: assert property (arTaken and s_axi_araddr == {`TCR_IDX_CARRY, 2'h0}
      |=> s_axi_rvalid && s_axi_rdata[31:1] == 31'h0)
      else $error("carry read shows more than bit zero");
   AST_AR_ANSWER: assert property (arTaken |=> s_axi_rvalid && !s_axi_arready)
      else $error("read not answered next cycle");
   AST_WDOG_CLEAR: assert property (watchdogStackReset |=> tickRateSel == 2'h0
      && timerRun == 3'h0 && timerClkSel == 6'h0 && !thirdTimerRun
      && !zerothTimerCountMode)
      else $error("watchdog reset left a control set");
   AST_STOP_KEEP: assert property (clockStop && !watchdogStackReset |=>
      timerRun == 3'h0 && !thirdTimerVsDacSel && !thirdTimerRun
      && tickRateSel == $past(tickRateSel))
      else $error("clock stop handled controls wrongly");
   AST_TICK_PULSE: assert property (basicTick |=> !basicTick)
      else $error("basic tick longer than one cycle");
endmodule

bind tcr_timer_control tcr_timer_control_props uProps (.clk, .resetn, .watchdogStackReset,
   .clockStop, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_bvalid, .s_axi_rvalid,
   .s_axi_rdata, .basicTick, .tickRateSel, .timerRun, .timerClear, .timerClkSel, .countTick,
   .thirdTimerVsDacSel, .thirdTimerRun, .thirdTimerClear, .zerothTimerCountMode);
`default_nettype wire

//--- tcr_timer_control_bench.sv
// Purpose: Register-level test of the timer control block over AXI4-Lite
// Assumes: Short divider periods set at the instance
// Notes:   Status bit zero follows the free basic tick, so it is masked out
`timescale 1ns/10ps
`default_nettype none
`include "tcr_timer_defines.svh"
module tcr_timer_control_bench;
   localparam int BTP [4] = '{40, 32, 24, 16};
   localparam int CTP [4] = '{12, 10, 8, 6};
   localparam logic [5:0] REGS [6] = '{`TCR_IDX_RATE, `TCR_IDX_T3CTL, `TCR_IDX_T2CTL,
      `TCR_IDX_T1CTL, `TCR_IDX_T0CTL, `TCR_IDX_T0MODE};
   localparam logic [3:0] FULL [6] = '{4'h3, 4'hA, 4'hB, 4'hB, 4'hB, 4'h7};
   logic        clk, resetn, watchdogStackReset, ceReset, clockStop, zerothTimerOverflowEvent;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic        irq, basicTick, thirdTimerVsDacSel, thirdTimerRun, thirdTimerClear;
   logic        zerothTimerCountMode, gateCloseEdgeSel, gateOpenEdgeSel;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [1:0]  s_axi_bresp, s_axi_rresp, tickRateSel;
   logic [2:0]  timerRun, timerClear, countTick;
   logic [5:0]  timerClkSel;
   int          fails, comparisons, cyc, clrCnt;

   tcr_timer_control #(.BT_P0(BTP[0]), .BT_P1(BTP[1]), .BT_P2(BTP[2]), .BT_P3(BTP[3]),
      .CT_P0(CTP[0]), .CT_P1(CTP[1]), .CT_P2(CTP[2]), .CT_P3(CTP[3])) DUT (.clk, .resetn,
      .watchdogStackReset, .ceReset, .clockStop, .zerothTimerOverflowEvent, .s_axi_awvalid,
      .s_axi_awready, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_wvalid, .s_axi_wready,
      .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
      .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_rvalid,
      .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .basicTick, .tickRateSel, .timerRun,
      .timerClear, .timerClkSel, .countTick, .thirdTimerVsDacSel, .thirdTimerRun,
      .thirdTimerClear, .zerothTimerCountMode, .gateCloseEdgeSel, .gateOpenEdgeSel, .irq);

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task give_verdict;
      $display("fails %0d comparisons %0d", fails, comparisons);
      if (fails == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   always @(posedge clk) begin
      cyc <= cyc + 1;
      clrCnt <= clrCnt + $countones({timerClear, thirdTimerClear});
      if (cyc == 6000) begin
         fails++;
         give_verdict();
      end
   end

   task automatic wr(input logic [5:0] idx, input logic [3:0] d, input logic [1:0] er = 2'h0);
      s_axi_awaddr <= {idx, 2'h0};
      s_axi_wdata <= {28'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      check("bresp", 32'(s_axi_bresp), 32'(er));
      @(posedge clk);
   endtask

   task automatic rd(input logic [5:0] idx, input logic [3:0] exp, input logic [1:0] er = 2'h0,
                     input logic [31:0] m = 32'hFFFFFFFF);
      s_axi_araddr <= {idx, 2'h0};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      check("rdata", s_axi_rdata & m, 32'(exp));
      check("rresp", 32'(s_axi_rresp), 32'(er));
      @(posedge clk);
   endtask

   // Order: watchdog, CE, clock stop, overflow event
   task automatic pulse(input logic [3:0] v);
      {watchdogStackReset, ceReset, clockStop, zerothTimerOverflowEvent} <= v;
      @(posedge clk);
      {watchdogStackReset, ceReset, clockStop, zerothTimerOverflowEvent} <= 4'h0;
      @(posedge clk);
   endtask

   // Cycles between the second and third tick after the call
   task automatic period(input logic which, input int exp);
      int n;
      n = 0;
      repeat (2) begin
         while (!(which ? countTick[0] : basicTick)) @(posedge clk);
         @(posedge clk);
      end
      while (!(which ? countTick[0] : basicTick)) begin
         @(posedge clk);
         n++;
      end
      check("tick period", 32'(n + 1), 32'(exp));
   endtask

   initial begin
      {resetn, watchdogStackReset, ceReset, clockStop, zerothTimerOverflowEvent} = 5'h0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
      s_axi_awaddr = 8'h0;
      s_axi_araddr = 8'h0;
      s_axi_wdata = 32'h0;
      repeat (16) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      rd(`TCR_IDX_CARRY, 4'h0);
      for (int i = 0; i < 6; i++) rd(REGS[i], 4'h0);
      rd(6'h3F, 4'h0, 2'h2);
      wr(6'h3F, 4'hF, 2'h2);
      for (int i = 0; i < 6; i++) wr(REGS[i], 4'hF);
      for (int i = 0; i < 6; i++) rd(REGS[i], FULL[i]);
      check("clear pulses", 32'(clrCnt), 32'h4);
      check("controls", 32'({tickRateSel, timerRun, timerClkSel,
         thirdTimerVsDacSel, thirdTimerRun, zerothTimerCountMode, gateCloseEdgeSel,
         gateOpenEdgeSel}), 32'hFFFF);
      wr(`TCR_IDX_T0CTL, 4'h8);
      check("clear pulses", 32'(clrCnt), 32'h4);
      for (int k = 0; k < 4; k++) begin
         wr(`TCR_IDX_T0CTL, 4'h8 | 4'(k));
         period(1'b1, CTP[k]);
      end
      wr(`TCR_IDX_T0CTL, 4'h0);
      repeat (30) @(posedge clk);
      for (int k = 0; k < 4; k++) begin
         wr(`TCR_IDX_RATE, 4'(k));
         period(1'b0, BTP[k]);
      end
      // Next tick is a full period away, so only the CE reset can set carry here
      while (!basicTick) @(posedge clk);
      rd(`TCR_IDX_CARRY, 4'h1);
      rd(`TCR_IDX_CARRY, 4'h0);
      pulse(4'h4);
      rd(`TCR_IDX_CARRY, 4'h1);
      wr(`TCR_IDX_T1CTL, 4'h9);
      pulse(4'h4);
      rd(`TCR_IDX_T1CTL, 4'h9);
      pulse(4'h8);
      rd(`TCR_IDX_CARRY, 4'h1);
      rd(`TCR_IDX_T1CTL, 4'h0);
      rd(`TCR_IDX_RATE, 4'h0);
      wr(`TCR_IDX_RATE, 4'h2);
      wr(`TCR_IDX_T0CTL, 4'hB);
      wr(`TCR_IDX_T3CTL, 4'hA);
      wr(`TCR_IDX_T0MODE, 4'h7);
      pulse(4'h2);
      rd(`TCR_IDX_RATE, 4'h2);
      rd(`TCR_IDX_T0CTL, 4'h0);
      rd(`TCR_IDX_T3CTL, 4'h0);
      rd(`TCR_IDX_T0MODE, 4'h0);
      wr(`TCR_IDX_IMASK, 4'h2);
      pulse(4'h1);
      rd(`TCR_IDX_T0MODE, 4'h8);
      check("irq", 32'(irq), 32'h1);
      rd(`TCR_IDX_ISTAT, 4'h2, 2'h0, 32'h2);
      check("irq", 32'(irq), 32'h0);
      wr(`TCR_IDX_T0MODE, 4'h0);
      rd(`TCR_IDX_T0MODE, 4'h0);
      wr(`TCR_IDX_IMASK, 4'h0);
      pulse(4'h1);
      check("irq", 32'(irq), 32'h0);
      wr(`TCR_IDX_IMASK, 4'h2);
      check("irq", 32'(irq), 32'h1);
      rd(`TCR_IDX_ISTAT, 4'h2, 2'h0, 32'h2);
      check("irq", 32'(irq), 32'h0);
      give_verdict();
   end
endmodule
`default_nettype wire
